// >>> rtl/lane_steer.sv
// Top: byte-lane steering between core load/store path and address-invariant bus
// What this block does
// - System bus lanes stay little-endian whatever mode the core uses.
// - Big-endian: base byte address picks the most significant byte.
// - Little-endian: base byte address picks the least significant byte.
// - Conversion reverses the four bytes of a word, or the two bytes of a half.
// - Little-endian passes words; half at offset 2 upper; byte on lane offset.
// - Bus is address-invariant: offset n on lane n, lane 0 at bits 7:0.
// - Big-endian: register word 01020304 appears on lanes as 04030201.
`timescale 1ns/1ps
`default_nettype none
module lane_steer
  import lane_steer_pkg::*;
(
  input wire logic clk_i, // 250 MHz core clock
  input wire logic nrst_i, // Async active-low reset
  input wire logic byte_order_select_i, // Status word bit: 1 little, 0 big
  input wire core_req_t core_req_i, // Load/store request from core
  input wire logic bus_rvalid_i, // Read data valid from bus
  input wire logic [31:0] bus_rdata_i, // Read data on bus lanes
  output bus_req_t bus_req_o, // Registered bus request
  output core_rsp_t core_rsp_o // Registered load data to core
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_s1_r, rst_s2_r;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  wire logic rst_n = rst_s2_r;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Lane mask of the addressed bytes; misaligned offsets are truncated
  function automatic logic [3:0] lane_mask(access_size_t sz, logic [1:0] off);
    logic [3:0] m;
    m = BE_WORD;
    case (sz)
      SIZE_BYTE: m = BE_BYTE << off;
      SIZE_HALF: m = BE_HALF << {off[1], 1'b0};
      default: m = BE_WORD;
    endcase
    return m;
  endfunction

  // Bit shift that moves lane 0 to the lane of the offset
  function automatic logic [4:0] lane_shift(access_size_t sz, logic [1:0] off);
    logic [4:0] s;
    s = 5'h00;
    case (sz)
      SIZE_BYTE: s = {off, 3'b000};
      SIZE_HALF: s = {off[1], 4'b0000};
      default: s = 5'h00;
    endcase
    return s;
  endfunction

  // ----------------------------------------------------------------
  // Store path
  // ----------------------------------------------------------------
  // Big mode: swap the register image first, then place. For a byte the swap
  // would move it to lane 3, so narrow data is pre-aligned into the low lanes
  // in register order and swapped only within its own width.
  logic big_mode;
  logic [31:0] wr_swapped, wr_pre;
  assign big_mode = (byte_order_select_i == BYTE_ORDER_BIG);

  always_comb begin
    wr_pre = core_req_i.data;
    if (big_mode && core_req_i.size == SIZE_HALF) begin
      wr_pre = {16'h0000, core_req_i.data[7:0], core_req_i.data[15:8]};
    end
  end

  lane_swap u_wr_swap (
    .swap_i(big_mode && core_req_i.size == SIZE_WORD),
    .data_i(wr_pre),
    .data_o(wr_swapped)
  );

  bus_req_t bus_req_r, bus_req_nxt;
  always_comb begin
    bus_req_nxt.valid = core_req_i.valid;
    bus_req_nxt.write = core_req_i.write;
    bus_req_nxt.offset = core_req_i.offset;
    bus_req_nxt.byte_en = core_req_i.write ?
        lane_mask(core_req_i.size, core_req_i.offset) : BE_WORD;
    // Offset n lands on lane n in both modes: the bus stays little-endian
    bus_req_nxt.data =
        wr_swapped << lane_shift(core_req_i.size, core_req_i.offset);
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      bus_req_r <= '{valid: 1'b0, write: 1'b0, offset: 2'h0, byte_en: BE_RST, data: DATA_RST};
    end else begin
      bus_req_r <= bus_req_nxt;
    end
  end
  assign bus_req_o = bus_req_r;

  // ----------------------------------------------------------------
  // Load path: remember size/offset/mode of each read
  // ----------------------------------------------------------------
  // Only one read outstanding is assumed; a new read overwrites the context
  access_size_t rd_size_r, rd_size_nxt;
  logic [1:0] rd_off_r, rd_off_nxt;
  logic rd_big_r, rd_big_nxt;
  always_comb begin
    rd_size_nxt = rd_size_r;
    rd_off_nxt = rd_off_r;
    rd_big_nxt = rd_big_r;
    if (core_req_i.valid && !core_req_i.write) begin
      rd_size_nxt = core_req_i.size;
      rd_off_nxt = core_req_i.offset;
      rd_big_nxt = big_mode;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rd_size_r <= SIZE_WORD;
      rd_off_r <= 2'h0;
      rd_big_r <= ~MODE_RST;
    end else begin
      rd_size_r <= rd_size_nxt;
      rd_off_r <= rd_off_nxt;
      rd_big_r <= rd_big_nxt;
    end
  end

  // Extract the addressed lanes, then undo the big-endian reorder
  logic [31:0] rd_low, rd_pre, rd_swapped;
  always_comb begin
    rd_low = bus_rdata_i >> lane_shift(rd_size_r, rd_off_r);
    rd_pre = rd_low;
    case (rd_size_r)
      SIZE_BYTE: rd_pre = {24'h00_0000, rd_low[7:0]};
      SIZE_HALF: rd_pre = rd_big_r ? {16'h0000, rd_low[7:0], rd_low[15:8]}
                                   : {16'h0000, rd_low[15:0]};
      default: rd_pre = rd_low;
    endcase
  end

  lane_swap u_rd_swap (
    .swap_i(rd_big_r && rd_size_r == SIZE_WORD),
    .data_i(rd_pre),
    .data_o(rd_swapped)
  );

  core_rsp_t core_rsp_r, core_rsp_nxt;
  always_comb begin
    core_rsp_nxt.valid = bus_rvalid_i;
    core_rsp_nxt.data = bus_rvalid_i ? rd_swapped : core_rsp_r.data;
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      core_rsp_r <= '{valid: 1'b0, data: DATA_RST};
    end else begin
      core_rsp_r <= core_rsp_nxt;
    end
  end
  assign core_rsp_o = core_rsp_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  a_big_word_swap: assert property (
    core_req_i.valid && core_req_i.write && core_req_i.size == SIZE_WORD && big_mode
    |=> bus_req_o.data == {$past(core_req_i.data[7:0]), $past(core_req_i.data[15:8]),
                           $past(core_req_i.data[23:16]), $past(core_req_i.data[31:24])})
    else $error("big-endian word not reversed");
  a_little_word_pass: assert property (
    core_req_i.valid && core_req_i.write && core_req_i.size == SIZE_WORD && !big_mode
    |=> bus_req_o.data == $past(core_req_i.data))
    else $error("little-endian word changed");
  a_byte_on_lane: assert property (
    core_req_i.valid && core_req_i.write && core_req_i.size == SIZE_BYTE
    |=> bus_req_o.data[bus_req_o.offset*8 +: 8] == $past(core_req_i.data[7:0]))
    else $error("byte not on its offset lane");
  a_byte_enable_one: assert property (
    core_req_i.valid && core_req_i.write && core_req_i.size == SIZE_BYTE
    |=> bus_req_o.byte_en == (4'h1 << bus_req_o.offset))
    else $error("byte enable wrong lane");
  a_half_enable_two: assert property (
    core_req_i.valid && core_req_i.write && core_req_i.size == SIZE_HALF
    |=> $countones(bus_req_o.byte_en) == 2 && bus_req_o.byte_en[0] == !bus_req_o.offset[1])
    else $error("half-word enables wrong");
  a_big_half_order: assert property (
    core_req_i.valid && core_req_i.write && core_req_i.size == SIZE_HALF && big_mode
    && core_req_i.offset == 2'h2
    |=> bus_req_o.data[31:16] == {$past(core_req_i.data[7:0]), $past(core_req_i.data[15:8])})
    else $error("big half-word order wrong");
  a_little_half_order: assert property (
    core_req_i.valid && core_req_i.write && core_req_i.size == SIZE_HALF && !big_mode
    && core_req_i.offset == 2'h2
    |=> bus_req_o.data[31:16] == $past(core_req_i.data[15:0]))
    else $error("little half-word order wrong");
  // Keyed on the stored read context, since the bus answers several cycles late
  a_load_roundtrip: assert property (
    bus_rvalid_i && rd_big_r && rd_size_r == SIZE_WORD
    |=> core_rsp_o.valid && core_rsp_o.data == {$past(bus_rdata_i[7:0]),
        $past(bus_rdata_i[15:8]), $past(bus_rdata_i[23:16]), $past(bus_rdata_i[31:24])})
    else $error("big word load not reversed");
  a_load_byte_zext: assert property (
    bus_rvalid_i && rd_size_r == SIZE_BYTE && !(core_req_i.valid && !core_req_i.write)
    |=> core_rsp_o.data[31:8] == 24'h00_0000)
    else $error("byte load not zero extended");

  c_big_word: cover property (core_req_i.valid && core_req_i.write && big_mode
    && core_req_i.size == SIZE_WORD);
  c_little_byte3: cover property (core_req_i.valid && core_req_i.write && !big_mode
    && core_req_i.size == SIZE_BYTE && core_req_i.offset == 2'h3);
  c_big_half_load: cover property (core_req_i.valid && !core_req_i.write && big_mode
    && core_req_i.size == SIZE_HALF ##3 bus_rvalid_i);

endmodule
`default_nettype wire

// >>> rtl/lane_steer_pkg.sv
// Package: constants and carrier types for the byte-lane steering block
package lane_steer_pkg;

  // ----------------------------------------------------------------
  // Access sizes and mode encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SIZE_BYTE = 2'h0,
    SIZE_HALF = 2'h1,
    SIZE_WORD = 2'h2
  } access_size_t;

  localparam logic BYTE_ORDER_BIG = 1'h0;
  localparam logic BYTE_ORDER_LITTLE = 1'h1;
  localparam logic MODE_RST = 1'h1;
  localparam logic [31:0] DATA_RST = 32'h0000_0000;
  localparam logic [3:0] BE_RST = 4'h0;
  localparam logic [3:0] BE_BYTE = 4'h1;
  localparam logic [3:0] BE_HALF = 4'h3;
  localparam logic [3:0] BE_WORD = 4'hf;
  localparam int LANE_W = 8;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic write;
    access_size_t size;
    logic [1:0] offset;
    logic [31:0] data;
  } core_req_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [1:0] offset;
    logic [3:0] byte_en;
    logic [31:0] data;
  } bus_req_t;

  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } core_rsp_t;

endpackage

// >>> rtl/lane_swap.sv
// Byte reversal stage used for big-endian traffic in both directions
`timescale 1ns/1ps
`default_nettype none
module lane_swap
  import lane_steer_pkg::*;
(
  input wire logic swap_i, // Reverse the four bytes when high
  input wire logic [31:0] data_i, // Word in
  output logic [31:0] data_o // Word out
);

  // Pure reorder of lanes, no other data change
  always_comb begin
    if (swap_i) begin
      data_o = {data_i[7:0], data_i[15:8], data_i[23:16], data_i[31:24]};
    end else begin
      data_o = data_i;
    end
  end

endmodule
`default_nettype wire

// >>> verification/highway_mem_model.sv
// Far-side model: one-word memory on the address-invariant bus lanes
`timescale 1ns/1ps
`default_nettype none
module highway_mem_model
  import lane_steer_pkg::*;
(
  input wire logic clk_i, // Core clock
  input wire logic slow_i, // Stretch read latency when high
  input wire bus_req_t bus_req_i, // Request from the steering block
  output logic bus_rvalid_o, // Read data valid pulse
  output logic [31:0] bus_rdata_o // Read data on lanes
);
  logic [31:0] mem = 32'h0000_0000;
  int wait_cnt = 0;
  initial bus_rvalid_o = 1'b0;
  initial bus_rdata_o = 32'hffff_ffff;
  // ------------------------------------------------
  // Lane n lands in byte n; idle lanes toggle so stale data never matches
  // ------------------------------------------------
  always @(posedge clk_i) begin
    bus_rvalid_o <= 1'b0;
    bus_rdata_o <= ~bus_rdata_o;
    if (bus_req_i.valid && bus_req_i.write) begin
      for (int n = 0; n < 4; n++)
        if (bus_req_i.byte_en[n]) mem[8*n +: 8] <= bus_req_i.data[8*n +: 8];
    end
    if (bus_req_i.valid && !bus_req_i.write) wait_cnt <= slow_i ? 4 : 1;
    else if (wait_cnt > 1) wait_cnt <= wait_cnt - 1;
    else if (wait_cnt == 1) begin
      wait_cnt <= 0;
      bus_rvalid_o <= 1'b1;
      bus_rdata_o <= mem;
    end
  end
endmodule
`default_nettype wire

// >>> verification/tb_lane_steer.sv
// Self-checking bench for the byte-lane steering block
`timescale 1ns/1ps
`default_nettype none
module tb_lane_steer;
  import lane_steer_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic mode = BYTE_ORDER_LITTLE;
  logic slow = 1'b0;
  logic rvalid;
  logic [31:0] rdata;
  logic [31:0] shadow = 32'h0000_0000;
  core_req_t req = '0;
  bus_req_t bus_req;
  core_rsp_t rsp;
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;
  lane_steer u_dut (.clk_i(clk), .nrst_i(nrst), .byte_order_select_i(mode), .core_req_i(req),
    .bus_rvalid_i(rvalid), .bus_rdata_i(rdata), .bus_req_o(bus_req), .core_rsp_o(rsp));
  highway_mem_model u_mem (.clk_i(clk), .slow_i(slow), .bus_req_i(bus_req),
    .bus_rvalid_o(rvalid), .bus_rdata_o(rdata));
  always #2 clk = ~clk;
  // Hang guard: the whole run needs under two hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      give_verdict();
    end
  end
  // ------------------------------------------------
  // Expectations from the lane rules
  // ------------------------------------------------
  function automatic logic [31:0] lanes(logic m, access_size_t s, logic [1:0] o,
    logic [31:0] d);
    logic [15:0] h;
    h = (m == BYTE_ORDER_BIG) ? {d[7:0], d[15:8]} : d[15:0];
    case (s)
      SIZE_WORD: return (m == BYTE_ORDER_BIG) ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
      SIZE_HALF: return {16'h0000, h} << (16 * o[1]);
      default: return {24'h00_0000, d[7:0]} << (8 * o);
    endcase
  endfunction
  function automatic logic [3:0] bemask(access_size_t s, logic [1:0] o);
    return (s == SIZE_WORD) ? BE_WORD :
        (s == SIZE_HALF) ? (BE_HALF << (2 * o[1])) : (BE_BYTE << o);
  endfunction
  function automatic logic [31:0] mask32(logic [3:0] be);
    for (int n = 0; n < 4; n++) mask32[8*n +: 8] = {8{be[n]}};
  endfunction
  // ------------------------------------------------
  // Shared tasks
  // ------------------------------------------------
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One store, judged on the cycle after it is taken
  task automatic store(input logic m, input access_size_t s, input logic [1:0] o,
    input logic [31:0] d);
    logic [31:0] msk;
    msk = mask32(bemask(s, o));
    tick();
    mode = m;
    req = '{1'b1, 1'b1, s, o, d};
    tick();
    req.valid = 1'b0;
    check("store kind", 32'h0000_0003, 32'({bus_req.valid, bus_req.write}));
    check("store offset", 32'(o), 32'(bus_req.offset));
    check("byte enables", 32'(bemask(s, o)), 32'(bus_req.byte_en));
    check("bus lanes", lanes(m, s, o, d) & msk, bus_req.data & msk);
    shadow = (shadow & ~msk) | (lanes(m, s, o, d) & msk);
  endtask
  // One load, answered by the memory model, result judged at the core side
  task automatic load(input logic m, input access_size_t s, input logic [1:0] o);
    int n;
    logic [31:0] want;
    want = lanes(m, s, 2'h0, shadow >> (8 * o)) & mask32(bemask(s, 2'h0));
    tick();
    mode = m;
    req = '{1'b1, 1'b0, s, o, 32'h0000_0000};
    tick();
    req.valid = 1'b0;
    check("load kind", 32'h0000_0002, 32'({bus_req.valid, bus_req.write}));
    check("read enables", 32'(BE_WORD), 32'(bus_req.byte_en));
    n = 0;
    while (rsp.valid !== 1'b1 && n < 20) begin
      tick();
      n++;
    end
    check("load valid", 32'h0000_0001, 32'(rsp.valid));
    check("load data", want, rsp.data);
    // Load valid is a single-cycle pulse
    tick();
    check("load pulse", 32'h0000_0000, 32'(rsp.valid));
  endtask
  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  // Word in both orders, then the base byte picks MSB or LSB
  task automatic t_words();
    store(BYTE_ORDER_BIG, SIZE_WORD, 2'h0, 32'h0102_0304);
    load(BYTE_ORDER_BIG, SIZE_WORD, 2'h0);
    load(BYTE_ORDER_BIG, SIZE_BYTE, 2'h0);
    store(BYTE_ORDER_LITTLE, SIZE_WORD, 2'h0, 32'h0102_0304);
    load(BYTE_ORDER_LITTLE, SIZE_BYTE, 2'h0);
    load(BYTE_ORDER_LITTLE, SIZE_WORD, 2'h0);
  endtask
  // Every byte and half placement in both modes, read back
  task automatic t_partial();
    for (int m = 0; m < 2; m++) begin
      for (int o = 0; o < 4; o++) begin
        store(m[0], SIZE_BYTE, o[1:0], 32'h0000_00a0 + o);
        load(m[0], SIZE_BYTE, o[1:0]);
        if (o[0] == 1'b0) begin
          store(m[0], SIZE_HALF, o[1:0], 32'h0000_0304);
          load(m[0], SIZE_HALF, o[1:0]);
        end
      end
    end
  endtask
  // Stores every cycle, then loads against a slow memory
  task automatic t_back2back();
    logic [31:0] d [3] = '{32'h1111_2222, 32'h3344_5566, 32'h7788_99aa};
    tick();
    mode = BYTE_ORDER_BIG;
    for (int k = 0; k < 3; k++) begin
      req = '{1'b1, 1'b1, SIZE_WORD, 2'h0, d[k]};
      tick();
      check("burst lanes", lanes(BYTE_ORDER_BIG, SIZE_WORD, 2'h0, d[k]), bus_req.data);
    end
    req.valid = 1'b0;
    shadow = lanes(BYTE_ORDER_BIG, SIZE_WORD, 2'h0, d[2]);
    slow = 1'b1;
    load(BYTE_ORDER_BIG, SIZE_WORD, 2'h0);
    load(BYTE_ORDER_BIG, SIZE_HALF, 2'h2);
    slow = 1'b0;
  endtask
  task automatic give_verdict();
    $display("TB: checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Main sequence: reset held ten cycles, then the scenarios
  initial begin
    repeat (10) @(posedge clk);
    #1;
    check("reset valid", 32'h0000_0000, 32'({bus_req.valid, rsp.valid}));
    check("reset enables", 32'(BE_RST), 32'(bus_req.byte_en));
    nrst = 1'b1;
    repeat (4) tick();
    t_words();
    t_partial();
    t_back2back();
    give_verdict();
  end
endmodule
`default_nettype wire
